// >>> verilog/fe_codec_pkg.sv
// ==========================================================
// shared constants and types of the symbol codec
package fe_codec_pkg;

  // ==========================================================
  // control code-groups
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_SSD_FIRST = 5'h18;
  localparam logic [4:0] CG_SSD_SECOND = 5'h11;
  localparam logic [4:0] CG_ESD_FIRST = 5'h0D;
  localparam logic [4:0] CG_ESD_SECOND = 5'h07;
  localparam logic [4:0] CG_HALT = 5'h04;

  // ==========================================================
  // nibbles and symbol timing
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [2:0] SYM_FIRST = 3'h0;
  localparam logic [2:0] SYM_LAST = 3'h4;
  localparam logic [2:0] SYM_STEP = 3'h1;

  // ==========================================================
  // scrambler seed and reset state
  localparam int SCR_WIDTH = 11;
  localparam int SCR_TAP_HI = 10;
  localparam int SCR_TAP_LO = 8;
  localparam int SEED_STRAP_HI = 4;
  localparam int SEED_STRAP_LO = 1;
  localparam logic [6:0] SEED_FILL = 7'h5A;
  localparam logic [10:0] SCR_RESET = 11'h7FF;
  localparam logic [1:0] SYNC_SETTLE = 2'h3;
  localparam logic [1:0] SETTLE_STEP = 2'h1;
  localparam logic [4:0] RX_LOCK_RUN = 5'h10;
  localparam logic [4:0] RUN_STEP = 5'h01;

  // ==========================================================
  // three-level sequence: zero, positive, zero, negative
  localparam logic [1:0] LVL_ZERO_RISE = 2'h0;
  localparam logic [1:0] LVL_POS = 2'h1;
  localparam logic [1:0] LVL_NEG = 2'h3;
  localparam logic [1:0] LVL_STEP = 2'h1;
  localparam logic NRZI_RESET = 1'b0;

  // ==========================================================
  // carriers and states
  typedef struct packed {
    logic scr_bypass;
    logic enc_bypass;
  } mode_t;

  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] nibble;
  } mii_rx_t;

  localparam mii_rx_t MII_RX_RESET = 6'h00;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_SSD_J = 3'h1,
    TX_SSD_K = 3'h3,
    TX_DATA = 3'h2,
    TX_ESD_T = 3'h6,
    TX_ESD_R = 3'h7
  } tx_state_t;

  typedef enum logic {
    RX_HUNT = 1'b0,
    RX_FRAME = 1'b1
  } rx_state_t;

endpackage : fe_codec_pkg

// >>> verilog/fe_lfsr_scrambler.sv
`timescale 1ns/1ps
// ==========================================================
// closed-loop 11-bit key generator, x^11 + x^9 + 1
module fe_lfsr_scrambler
  import fe_codec_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [SCR_WIDTH-1:0] seed,
  input wire logic load,
  input wire logic train,
  input wire logic train_bit,
  output logic key
);

  logic [SCR_WIDTH-1:0] state_reg;
  logic [SCR_WIDTH-1:0] state_next;
  wire logic feedback = state_reg[SCR_TAP_HI] ^ state_reg[SCR_TAP_LO];

  // train shifts in the observed key so a receiver can lock on idle
  assign state_next = load ? seed :
                      {state_reg[SCR_WIDTH-2:0], train ? train_bit : feedback};
  assign key = feedback;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= SCR_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : fe_lfsr_scrambler

// >>> verilog/fe_symbol_codec.sv
`timescale 1ns/1ps
// Behaviour
// - nibbles map to fixed 5-bit code-groups
// - first preamble byte becomes J then K
// - transmit enable drop emits T then R
// - idle fill after R until next frame
// - halt code-group flags an error
// - J and K decode to 0101
// - idle code-group decodes to 0000
// - T and R decode to 0000
// - unassigned or misplaced control codes raise error
// - scrambler is closed-loop 11-bit LFSR
// - key XORed bitwise with serial NRZ
// - seed taken from upper four address straps
// - scrambled stream is NRZI encoded
// - NRZI split into two alternating phased streams
// - three-level output plus binary NRZI on tx_nrzi, no mode select
// - receive returns three-level stream to nibbles
// - scrambler and encoder each bypassable
// - J/K gives 0101 pair; stop on T/R, idles
module fe_symbol_codec
  import fe_codec_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [4:0] port_address_straps,
  input wire mode_t mode_pins,
  input wire logic tx_en,
  input wire logic [3:0] tx_nibble,
  input wire logic [4:0] tx_raw_group,
  input wire logic rx_mlt_pos,
  input wire logic rx_mlt_neg,
  output logic tx_nib_req,
  output logic tx_mlt_pos,
  output logic tx_mlt_neg,
  output logic tx_nrzi,
  output mii_rx_t rx_mii,
  output logic rx_nib_strobe
);

  // ==========================================================
  // code-group tables
  function automatic logic [4:0] encode_nibble(input logic [3:0] nib);
    logic [4:0] cg;
    cg = CG_HALT;
    unique case (nib)
      4'h0: cg = 5'h1E;
      4'h1: cg = 5'h09;
      4'h2: cg = 5'h14;
      4'h3: cg = 5'h15;
      4'h4: cg = 5'h0A;
      4'h5: cg = 5'h0B;
      4'h6: cg = 5'h0E;
      4'h7: cg = 5'h0F;
      4'h8: cg = 5'h12;
      4'h9: cg = 5'h13;
      4'hA: cg = 5'h16;
      4'hB: cg = 5'h17;
      4'hC: cg = 5'h1A;
      4'hD: cg = 5'h1B;
      4'hE: cg = 5'h1C;
      4'hF: cg = 5'h1D;
    endcase
    return cg;
  endfunction : encode_nibble

  // returns {is_data, nibble}; control groups carry their fixed nibble
  function automatic logic [4:0] decode_group(input logic [4:0] cg);
    logic [4:0] res;
    res = {1'b0, NIB_ZERO};
    case (cg)
      5'h1E: res = {1'b1, 4'h0};
      5'h09: res = {1'b1, 4'h1};
      5'h14: res = {1'b1, 4'h2};
      5'h15: res = {1'b1, 4'h3};
      5'h0A: res = {1'b1, 4'h4};
      5'h0B: res = {1'b1, 4'h5};
      5'h0E: res = {1'b1, 4'h6};
      5'h0F: res = {1'b1, 4'h7};
      5'h12: res = {1'b1, 4'h8};
      5'h13: res = {1'b1, 4'h9};
      5'h16: res = {1'b1, 4'hA};
      5'h17: res = {1'b1, 4'hB};
      5'h1A: res = {1'b1, 4'hC};
      5'h1B: res = {1'b1, 4'hD};
      5'h1C: res = {1'b1, 4'hE};
      5'h1D: res = {1'b1, 4'hF};
      CG_SSD_FIRST, CG_SSD_SECOND: res = {1'b0, NIB_PREAMBLE};
      CG_IDLE: res = {1'b0, NIB_ZERO};
      CG_ESD_FIRST, CG_ESD_SECOND: res = {1'b0, NIB_ZERO};
      default: res = {1'b0, NIB_ZERO};
    endcase
    return res;
  endfunction : decode_group

  // one step of the three-level sequence on a logic one
  function automatic logic [1:0] mlt_step(input logic [1:0] lvl, input logic one);
    return one ? lvl + LVL_STEP : lvl;
  endfunction : mlt_step

  // ==========================================================
  // pin synchronisers
  logic [8:0] pin_sync1_reg;
  logic [8:0] pin_sync2_reg;
  wire logic [8:0] pin_raw = {port_address_straps, mode_pins, rx_mlt_pos, rx_mlt_neg};
  wire logic [4:0] straps_s = pin_sync2_reg[8:4];
  wire mode_t mode_s = pin_sync2_reg[3:2];
  wire logic [1:0] rx_lvl_s = pin_sync2_reg[1:0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_sync1_reg <= 9'h000;
      pin_sync2_reg <= 9'h000;
    end else begin
      pin_sync1_reg <= pin_raw;
      pin_sync2_reg <= pin_sync1_reg;
    end
  end

  // ==========================================================
  // seed capture after reset release
  logic [1:0] settle_reg;
  logic [SCR_WIDTH-1:0] seed_reg;
  logic seed_load_reg;
  wire logic settling = settle_reg != SYNC_SETTLE;
  wire logic seed_take = settle_reg == SYNC_SETTLE - SETTLE_STEP;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_reg <= 2'h0;
      seed_reg <= SCR_RESET;
      seed_load_reg <= 1'b0;
    end else begin
      settle_reg <= settling ? settle_reg + SETTLE_STEP : settle_reg;
      seed_load_reg <= seed_take;
      if (seed_take) begin
        seed_reg <= {straps_s[SEED_STRAP_HI:SEED_STRAP_LO], SEED_FILL};
      end
    end
  end

  // ==========================================================
  // transmit code-group sequencing
  tx_state_t tx_state_reg;
  tx_state_t tx_state_next;
  logic [2:0] tx_bit_reg;
  logic [4:0] tx_shift_reg;
  logic [4:0] tx_group;
  wire logic tx_boundary = tx_bit_reg == SYM_LAST;
  wire logic [2:0] tx_bit_next = tx_boundary ? SYM_FIRST : tx_bit_reg + SYM_STEP;
  wire logic [4:0] tx_data_group = mode_s.enc_bypass ? tx_raw_group :
                                   encode_nibble(tx_nibble);

  always_comb begin
    tx_state_next = tx_state_reg;
    unique case (tx_state_reg)
      TX_IDLE: tx_state_next = tx_en ? TX_SSD_J : TX_IDLE;
      TX_SSD_J: tx_state_next = TX_SSD_K;
      TX_SSD_K: tx_state_next = tx_en ? TX_DATA : TX_ESD_T;
      TX_DATA: tx_state_next = tx_en ? TX_DATA : TX_ESD_T;
      TX_ESD_T: tx_state_next = TX_ESD_R;
      TX_ESD_R: tx_state_next = tx_en ? TX_SSD_J : TX_IDLE;
    endcase
  end

  always_comb begin
    tx_group = CG_IDLE;
    unique case (tx_state_next)
      TX_IDLE: tx_group = CG_IDLE;
      TX_SSD_J: tx_group = CG_SSD_FIRST;
      TX_SSD_K: tx_group = CG_SSD_SECOND;
      TX_DATA: tx_group = tx_data_group;
      TX_ESD_T: tx_group = CG_ESD_FIRST;
      TX_ESD_R: tx_group = CG_ESD_SECOND;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_reg <= TX_IDLE;
      tx_bit_reg <= SYM_FIRST;
      tx_shift_reg <= CG_IDLE;
      tx_nib_req <= 1'b0;
    end else begin
      tx_bit_reg <= tx_bit_next;
      tx_nib_req <= tx_bit_next == SYM_LAST;
      if (tx_boundary) begin
        tx_state_reg <= tx_state_next;
        tx_shift_reg <= tx_group;
      end else begin
        tx_shift_reg <= {tx_shift_reg[3:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // transmit scrambling, NRZI and three-level split
  logic tx_key;
  logic [1:0] tx_lvl_reg;
  wire logic tx_nrz = tx_shift_reg[4];
  wire logic tx_scr_bit = tx_nrz ^ (tx_key & ~mode_s.scr_bypass);
  wire logic [1:0] tx_lvl_next = mlt_step(tx_lvl_reg, tx_scr_bit);

  fe_lfsr_scrambler u_tx_scrambler (
    .clk(clk),
    .rst_b(rst_b),
    .seed(seed_reg),
    .load(seed_load_reg),
    .train(1'b0),
    .train_bit(1'b0),
    .key(tx_key)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_nrzi <= NRZI_RESET;
      tx_lvl_reg <= LVL_ZERO_RISE;
      tx_mlt_pos <= 1'b0;
      tx_mlt_neg <= 1'b0;
    end else begin
      tx_nrzi <= tx_nrzi ^ tx_scr_bit;
      tx_lvl_reg <= tx_lvl_next;
      tx_mlt_pos <= tx_lvl_next == LVL_POS;
      tx_mlt_neg <= tx_lvl_next == LVL_NEG;
    end
  end

  // ==========================================================
  // receive: three-level to NRZ, descrambling, alignment
  logic [1:0] rx_lvl_prev_reg;
  logic rx_key;
  logic [9:0] rx_win_reg;
  logic [2:0] rx_bit_reg;
  rx_state_t rx_state_reg;
  wire logic rx_nrz = rx_lvl_s != rx_lvl_prev_reg;
  wire logic rx_bit = rx_nrz ^ (rx_key & ~mode_s.scr_bypass);
  wire logic rx_hunting = rx_state_reg == RX_HUNT;
  wire logic [4:0] rx_first = rx_win_reg[9:5];
  wire logic [4:0] rx_second = rx_win_reg[4:0];
  wire logic rx_ssd = rx_first == CG_SSD_FIRST && rx_second == CG_SSD_SECOND;
  wire logic rx_esd = rx_first == CG_ESD_FIRST && rx_second == CG_ESD_SECOND;
  wire logic rx_idles = rx_first == CG_IDLE && rx_second == CG_IDLE;
  wire logic rx_boundary = rx_bit_reg == SYM_LAST;
  wire logic [4:0] rx_dec = decode_group(rx_first);
  wire logic rx_halt = rx_first == CG_HALT;
  wire logic rx_stop = rx_esd || rx_idles;
  // lock: a run of descrambled ones longer than the key register
  // proves the local key matches the far scrambler
  logic [4:0] rx_run_reg;
  logic rx_locked_reg;
  logic rx_k_pending_reg;
  wire logic rx_relock = mode_s.scr_bypass || seed_load_reg;
  wire logic rx_run_full = rx_run_reg == RX_LOCK_RUN;
  wire logic rx_run_grow = rx_bit && !rx_run_full;
  wire logic [4:0] rx_run_next = rx_run_grow ? rx_run_reg + RUN_STEP :
                                 (rx_bit ? rx_run_reg : 5'h00);
  wire logic rx_key_ok = rx_locked_reg || mode_s.scr_bypass;
  wire logic rx_training = rx_hunting && !rx_locked_reg;
  wire logic rx_start = rx_hunting && rx_ssd && rx_key_ok;
  wire logic rx_sym_take = !rx_hunting && rx_boundary;

  // ==========================================================
  // descrambler lock tracking
  // training stops once locked, so the zeros of J and K
  // cannot pull the key away from the far scrambler
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_run_reg <= 5'h00;
      rx_locked_reg <= 1'b0;
    end else if (rx_relock) begin
      rx_run_reg <= 5'h00;
      rx_locked_reg <= 1'b0;
    end else begin
      rx_run_reg <= rx_run_next;
      rx_locked_reg <= rx_locked_reg || rx_run_full;
    end
  end

  // idle on the line is all ones before scrambling, so its inverse is the key
  fe_lfsr_scrambler u_rx_descrambler (
    .clk(clk),
    .rst_b(rst_b),
    .seed(seed_reg),
    .load(seed_load_reg),
    .train(rx_training),
    .train_bit(~rx_nrz),
    .key(rx_key)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_lvl_prev_reg <= LVL_ZERO_RISE;
      rx_win_reg <= 10'h3FF;
      rx_bit_reg <= SYM_FIRST;
      rx_state_reg <= RX_HUNT;
    end else begin
      rx_lvl_prev_reg <= rx_lvl_s;
      rx_win_reg <= {rx_win_reg[8:0], rx_bit};
      rx_bit_reg <= (rx_start || rx_boundary) ? SYM_FIRST : rx_bit_reg + SYM_STEP;
      if (rx_start) begin
        rx_state_reg <= RX_FRAME;
      end else if (rx_sym_take && rx_stop) begin
        rx_state_reg <= RX_HUNT;
      end
    end
  end

  // ==========================================================
  // receive nibble presentation
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_mii <= MII_RX_RESET;
      rx_nib_strobe <= 1'b0;
    end else begin
      rx_nib_strobe <= rx_start || rx_sym_take;
      if (rx_start) begin
        rx_mii <= '{dv: 1'b1, er: 1'b0, nibble: NIB_PREAMBLE};
      end else if (rx_sym_take && rx_stop) begin
        rx_mii <= '{dv: 1'b0, er: 1'b0, nibble: rx_dec[3:0]};
      end else if (rx_sym_take && rx_k_pending_reg) begin
        rx_mii <= '{dv: 1'b1, er: 1'b0, nibble: NIB_PREAMBLE};
      end else if (rx_sym_take) begin
        rx_mii <= '{dv: 1'b1, er: ~rx_dec[4] | rx_halt, nibble: rx_dec[3:0]};
      end
    end
  end

  // ==========================================================
  // second start group of the pair: one symbol after detection
  // the K group sits in the upper half of the window and must
  // still read as preamble, not as a misplaced control code

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_k_pending_reg <= 1'b0;
    end else begin
      rx_k_pending_reg <= rx_start ? 1'b1 : (rx_sym_take ? 1'b0 : rx_k_pending_reg);
    end
  end

endmodule : fe_symbol_codec

// >>> testbench/fe_codec_chk_sva.sv
`timescale 1ns/1ps
// ==========================================================
// port checker of the symbol codec
module fe_codec_chk
  import fe_codec_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tx_nib_req,
  input wire logic tx_mlt_pos,
  input wire logic tx_mlt_neg,
  input wire mii_rx_t rx_mii,
  input wire logic rx_nib_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic last_pos_reg;
  logic last_pos_next;
  // remembers the sign of the last nonzero line level
  assign last_pos_next = tx_mlt_pos ? 1'b1 : (tx_mlt_neg ? 1'b0 : last_pos_reg);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_pos_reg <= 1'b0;
    end else begin
      last_pos_reg <= last_pos_next;
    end
  end
  chk_level_excl: assert property (!(tx_mlt_pos && tx_mlt_neg))
    else $error("both line phases high");
  chk_pos_after_neg: assert property ($rose(tx_mlt_pos) |-> !last_pos_reg)
    else $error("positive level repeated");
  chk_neg_after_pos: assert property ($rose(tx_mlt_neg) |-> last_pos_reg)
    else $error("negative level out of turn");
  chk_req_period: assert property (tx_nib_req |=> !tx_nib_req [*4] ##1 tx_nib_req)
    else $error("nibble request not every five cycles");
  chk_strobe_gap: assert property (rx_nib_strobe |=> !rx_nib_strobe [*4])
    else $error("receive strobes too close");
  chk_rx_hold: assert property (!rx_nib_strobe |-> $stable(rx_mii))
    else $error("receive nibble moved without strobe");
  chk_end_zero: assert property (rx_nib_strobe && !rx_mii.dv |-> rx_mii.nibble == NIB_ZERO)
    else $error("end of frame nibble not zero");
  chk_start_pre: assert property ($rose(rx_mii.dv) |->
    rx_nib_strobe && !rx_mii.er && rx_mii.nibble == NIB_PREAMBLE)
    else $error("frame start not preamble");
endmodule : fe_codec_chk

bind fe_symbol_codec fe_codec_chk i_chk (.clk, .rst_b, .tx_nib_req, .tx_mlt_pos,
  .tx_mlt_neg, .rx_mii, .rx_nib_strobe);

// >>> testbench/fe_mac_model.sv
`timescale 1ns/1ps
// ==========================================================
// mac nibble source
module fe_mac_model (
  input wire logic clk,
  input wire logic tx_nib_req,
  output logic tx_en,
  output logic [3:0] tx_nibble
);
  initial begin
    tx_en = 1'b0;
    tx_nibble = 4'h0;
  end
  // two preamble nibbles lead, low nibble of nibs goes first
  task automatic send_frame(input logic [63:0] nibs, input int n);
    logic [71:0] all;
    all = {nibs, 8'h55};
    for (int i = 0; i < n + 2; i++) begin
      @(negedge clk iff tx_nib_req === 1'b1);
      tx_en = 1'b1;
      tx_nibble = all[4*i +: 4];
    end
    @(negedge clk iff tx_nib_req === 1'b1);
    tx_en = 1'b0;
    tx_nibble = ~tx_nibble;
  endtask : send_frame
endmodule : fe_mac_model

// >>> testbench/fast_ethernet_tx_symbol_encoder_tb.sv
`timescale 1ns/1ps
// ==========================================================
// codec bench, line looped back into the receiver
module fast_ethernet_tx_symbol_encoder_tb
  import fe_codec_pkg::*;
;
  localparam logic [63:0] ALL_NIBS = 64'hFEDCBA9876543210;
  logic clk, rst_b, tx_en, tx_nib_req, tx_mlt_pos, tx_mlt_neg, tx_nrzi, rx_nib_strobe;
  logic nrzi_prev = 1'b0;
  mode_t mode_pins;
  logic [4:0] tx_raw_group;
  logic [3:0] tx_nibble;
  logic [9:0] win = 10'h000;
  mii_rx_t rx_mii;
  mii_rx_t rxq[$];
  int bad_count, compares, cyc;
  logic [4:0] cg_tab [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic [4:0] bad_tab [8] = '{CG_HALT, 5'h00, 5'h0C, CG_IDLE, 5'h01, CG_SSD_FIRST,
    CG_ESD_FIRST, CG_ESD_SECOND};

  fe_symbol_codec i_dut (.clk(clk), .rst_b(rst_b), .port_address_straps(5'h16),
    .mode_pins(mode_pins), .tx_en(tx_en), .tx_nibble(tx_nibble), .tx_raw_group(tx_raw_group),
    .rx_mlt_pos(tx_mlt_pos), .rx_mlt_neg(tx_mlt_neg), .tx_nib_req(tx_nib_req),
    .tx_mlt_pos(tx_mlt_pos), .tx_mlt_neg(tx_mlt_neg), .tx_nrzi(tx_nrzi), .rx_mii(rx_mii),
    .rx_nib_strobe(rx_nib_strobe));
  fe_mac_model i_mac (.clk(clk), .tx_nib_req(tx_nib_req), .tx_en(tx_en), .tx_nibble(tx_nibble));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // nrz bits recovered from the nrzi output, received nibbles queued
  always @(negedge clk) begin
    if (rx_nib_strobe === 1'b1) rxq.push_back(rx_mii);
    win <= {win[8:0], tx_nrzi ^ nrzi_prev};
    nrzi_prev <= tx_nrzi;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      finish_test();
    end
  end

  // ==========================================================
  // compares and helpers
  task automatic check5(input logic [4:0] got, input logic [4:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t group %b expected %b", $time, got, exp);
    end
  endtask : check5
  task automatic check_rx(input mii_rx_t got, input mii_rx_t exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t rx %h expected %h", $time, got, exp);
    end
  endtask : check_rx
  task automatic next5(input logic [4:0] exp);
    repeat (5) @(negedge clk);
    check5(win[4:0], exp);
  endtask : next5
  task automatic set_mode(input mode_t m);
    @(negedge clk);
    mode_pins = m;
    repeat (60) @(negedge clk);
    rxq.delete();
  endtask : set_mode
  task automatic wait_rx_end();
    int k;
    k = 0;
    while (!(rxq.size() > 0 && rxq[$].dv === 1'b0) && k < 400) begin
      @(negedge clk);
      k++;
    end
    if (k >= 400) begin
      bad_count++;
      $display("ERROR %0t receive frame end not seen", $time);
    end
  endtask : wait_rx_end
  task automatic check_rx_frame(input logic [63:0] nibs, input int n);
    wait_rx_end();
    check_rx(rxq[0], {1'b1, 1'b0, NIB_PREAMBLE});
    check_rx(rxq[1], {1'b1, 1'b0, NIB_PREAMBLE});
    for (int i = 0; i < n; i++) begin
      check_rx(rxq[i+2], {1'b1, 1'b0, nibs[4*i +: 4]});
    end
    check_rx(rxq[n+2], {1'b0, 1'b0, NIB_ZERO});
  endtask : check_rx_frame

  // ==========================================================
  // scenarios
  task automatic test_tx_table();
    int k;
    set_mode(2'b10);
    fork
      i_mac.send_frame(ALL_NIBS, 16);
      begin
        k = 0;
        while (win !== {CG_SSD_FIRST, CG_SSD_SECOND} && k < 300) begin
          @(negedge clk);
          k++;
        end
        check5(win[9:5], CG_SSD_FIRST);
        check5(win[4:0], CG_SSD_SECOND);
        for (int i = 0; i < 16; i++) begin
          next5(cg_tab[i]);
        end
        next5(CG_ESD_FIRST);
        next5(CG_ESD_SECOND);
        next5(CG_IDLE);
        next5(CG_IDLE);
      end
    join
    check_rx_frame(ALL_NIBS, 16);
  endtask : test_tx_table
  task automatic test_scrambled();
    set_mode(2'b00);
    i_mac.send_frame(ALL_NIBS, 16);
    check_rx_frame(ALL_NIBS, 16);
  endtask : test_scrambled
  task automatic test_bad_codes();
    set_mode(2'b01);
    for (int i = 0; i < 8; i++) begin
      tx_raw_group = bad_tab[i];
      rxq.delete();
      i_mac.send_frame(64'h0, 1);
      wait_rx_end();
      check_rx({rxq[2].dv, rxq[2].er, 4'h0}, 6'h30);
    end
  endtask : test_bad_codes
  task automatic finish_test();
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    rst_b = 1'b0;
    mode_pins = 2'b00;
    tx_raw_group = 5'h00;
    bad_count = 0;
    compares = 0;
    cyc = 0;
    repeat (12) @(negedge clk);
    check5({tx_nrzi, tx_mlt_pos, tx_mlt_neg, rx_nib_strobe, tx_nib_req}, 5'h00);
    rst_b = 1'b1;
    test_tx_table();
    test_scrambled();
    test_bad_codes();
    finish_test();
  end
endmodule : fast_ethernet_tx_symbol_encoder_tb
